// file: verilog/adc_repeat_sweep_sequencer.sv
// repeat sweep sequencer of the converter with its apb register file
`include "adc_sweep_defines.svh"
module adc_repeat_sweep_sequencer #(
  parameter int unsigned NUM_RESULTS = 8
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // start sources
  input wire logic timer_unit_one_trigger,
  input wire logic timer_unit_two_trigger,
  input wire logic ext_trigger,
  // analog front end
  output adc_sweep_pkg::conv_req_t conv_req,
  input wire adc_sweep_pkg::conv_rsp_t conv_rsp,
  // interrupt
  output logic irq
);
  // ==========================================
  // input synchronisers
  logic [2:0] trig_meta;
  logic [2:0] trig_sync;
  logic [2:0] trig_prev;
  logic [2:0] trig_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_meta <= 3'h0;
      trig_sync <= 3'h0;
      trig_prev <= 3'h0;
    end else begin
      trig_meta <= {ext_trigger, timer_unit_two_trigger, timer_unit_one_trigger};
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end
  assign trig_rise = trig_sync & ~trig_prev;

  // ==========================================
  // group decode
  function automatic logic [3:0] first_channel(input logic [1:0] gsel);
    first_channel = gsel[0] ? 4'h8 : 4'h0;
  endfunction : first_channel

  function automatic logic [3:0] last_channel(input logic [1:0] gsel, input logic [1:0] scan);
    logic [3:0] base;
    logic [1:0] eff;
    base = first_channel(gsel);
    eff = (gsel[0] && scan[1]) ? 2'h1 : scan; // upper group has two or four pins only
    unique case (eff)
      2'h0: last_channel = 4'(base + 4'h1);
      2'h1: last_channel = 4'(base + 4'h3);
      2'h2: last_channel = 4'h5;
      2'h3: last_channel = 4'h7;
    endcase
  endfunction : last_channel

  // ==========================================
  // apb decode
  logic wr;
  logic rd;
  logic setup;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign rd = setup && !pwrite;

  // ==========================================
  // configuration registers
  logic run;
  logic next_run;
  logic [1:0] trig_sel;
  logic [1:0] next_trig_sel;
  logic res10;
  logic next_res10;
  logic [1:0] scan;
  logic [1:0] next_scan;
  logic [1:0] gsel;
  logic [1:0] next_gsel;

  always_comb begin
    next_run = run;
    next_trig_sel = trig_sel;
    next_res10 = res10;
    next_scan = scan;
    next_gsel = gsel;
    if (wr) begin
      unique case (paddr)
        `OFF_CTRL0: begin
          next_run = pwdata[`CTRL0_RUN_BIT];
          next_trig_sel = pwdata[`CTRL0_TRIG_LSB +: 2];
        end
        `OFF_CTRL1: next_res10 = pwdata[`CTRL1_RES10_BIT];
        `OFF_INSEL: begin
          next_scan = pwdata[`INSEL_SCAN_LSB +: 2];
          next_gsel = pwdata[`INSEL_GSEL_LSB +: 2];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {trig_sel, run} <= 3'(`CTRL0_RESET);
      res10 <= 1'b0;
      scan <= 2'h0;
      gsel <= 2'h0;
    end else begin
      run <= next_run;
      trig_sel <= next_trig_sel;
      res10 <= next_res10;
      scan <= next_scan;
      gsel <= next_gsel;
    end
  end

  // ==========================================
  // sweep sequencer
  adc_sweep_pkg::seq_state_t state;
  adc_sweep_pkg::seq_state_t next_state;
  logic [3:0] chan;
  logic [3:0] next_chan;
  adc_sweep_pkg::conv_req_t next_conv_req;
  logic start_hit;
  logic converting;
  logic conv_done;
  logic sweep_end;
  logic [9:0] store_code;

  always_comb begin
    unique case (adc_sweep_pkg::trig_src_t'(trig_sel))
      adc_sweep_pkg::trig_soft: start_hit = 1'b1;
      adc_sweep_pkg::trig_timer1: start_hit = trig_rise[0];
      adc_sweep_pkg::trig_timer2: start_hit = trig_rise[1];
      adc_sweep_pkg::trig_ext: start_hit = trig_rise[2];
    endcase
  end

  assign converting = state == adc_sweep_pkg::st_convert;
  // a result counts only while running, so a forced stop drops it
  assign conv_done = run && converting && conv_rsp.done;
  assign sweep_end = conv_done && chan == last_channel(gsel, scan);
  // 8-bit results keep the upper code bits, right aligned
  assign store_code = res10 ? conv_rsp.code : {2'h0, conv_rsp.code[9:2]};

  always_comb begin
    next_state = state;
    next_chan = chan;
    next_conv_req = conv_req;
    next_conv_req.req = 1'b0;
    if (!run) begin
      next_state = adc_sweep_pkg::st_idle;
    end else begin
      unique case (state)
        adc_sweep_pkg::st_idle: next_state = adc_sweep_pkg::st_wait_trig;
        adc_sweep_pkg::st_wait_trig: begin
          if (start_hit) begin
            next_chan = first_channel(gsel);
            next_state = adc_sweep_pkg::st_convert;
            next_conv_req = '{req: 1'b1, channel: first_channel(gsel), res10: res10};
          end
        end
        adc_sweep_pkg::st_convert: begin
          if (conv_done) begin
            if (sweep_end) begin
              next_chan = first_channel(gsel);
            end else begin
              next_chan = 4'(chan + 4'h1);
            end
            next_conv_req = '{req: 1'b1, channel: next_chan, res10: res10};
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= adc_sweep_pkg::st_idle;
      chan <= 4'h0;
      conv_req <= '0;
    end else begin
      state <= next_state;
      chan <= next_chan;
      conv_req <= next_conv_req;
    end
  end

  // ==========================================
  // result registers
  logic [9:0] result [NUM_RESULTS];

  for (genvar g = 0; g < NUM_RESULTS; g++) begin : g_result
    logic [9:0] next_value;
    always_comb begin
      next_value = result[g];
      if (conv_done && chan[2:0] == 3'(g)) begin
        next_value = store_code;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        result[g] <= 10'h0;
      end else begin
        result[g] <= next_value;
      end
    end
  end

  // ==========================================
  // interrupt
  logic irq_stat;
  logic next_irq_stat;
  logic irq_mask;
  logic next_irq_mask;
  logic next_irq;

  always_comb begin
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    if (wr && paddr == `OFF_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~pwdata[`IRQ_SWEEP_BIT];
    end
    if (wr && paddr == `OFF_IRQ_MASK) begin
      next_irq_mask = pwdata[`IRQ_SWEEP_BIT];
    end
    // a sweep ending in the clearing cycle wins over the clear
    if (sweep_end) begin
      next_irq_stat = 1'b1;
    end
    next_irq = next_irq_stat & next_irq_mask;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 1'b0;
      irq_mask <= `IRQ_MASK_RESET;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end

  // ==========================================
  // read data
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = prdata;
    if (rd) begin
      next_prdata = 32'h0;
      if (paddr == `OFF_CTRL0) next_prdata = {29'h0, trig_sel, run};
      else if (paddr == `OFF_CTRL1) next_prdata = {31'h0, res10};
      else if (paddr == `OFF_INSEL) next_prdata = {26'h0, gsel, 2'h0, scan};
      else if (paddr == `OFF_STATUS) next_prdata = {26'h0, chan, converting, run};
      else if (paddr == `OFF_IRQ_STAT) next_prdata = {31'h0, irq_stat};
      else if (paddr == `OFF_IRQ_MASK) next_prdata = {31'h0, irq_mask};
      else if (paddr[11:5] == 7'h1) next_prdata = {22'h0, result[paddr[4:2]]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ==========================================
  // apb response
  // zero wait state slave, no errors
  logic next_pready;
  logic next_pslverr;

  assign next_pready = 1'b1;
  assign next_pslverr = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule : adc_repeat_sweep_sequencer

// file: inc/adc_sweep_defines.svh
// register offsets, field positions, reset values and timing counts of the sweep sequencer
`ifndef ADC_SWEEP_DEFINES_SVH
`define ADC_SWEEP_DEFINES_SVH
`define OFF_CTRL0 12'h000
`define OFF_CTRL1 12'h004
`define OFF_INSEL 12'h008
`define OFF_STATUS 12'h00c
`define OFF_IRQ_STAT 12'h010
`define OFF_IRQ_MASK 12'h014
`define OFF_RESULT0 12'h020
`define CTRL0_RUN_BIT 0
`define CTRL0_TRIG_LSB 1
`define CTRL1_RES10_BIT 0
`define INSEL_SCAN_LSB 0
`define INSEL_GSEL_LSB 4
`define IRQ_SWEEP_BIT 0
`define CTRL0_RESET 32'h0000_0000
`define IRQ_MASK_RESET 1'b0
`define CONV_CYCLES 8'd22
`endif

// file: inc/adc_sweep_pkg.sv
// types of the sweep sequencer
package adc_sweep_pkg;
  typedef enum logic [1:0] {trig_soft, trig_timer1, trig_timer2, trig_ext} trig_src_t;
  typedef enum {st_idle, st_wait_trig, st_convert} seq_state_t;
  typedef struct packed {
    logic req;
    logic [3:0] channel;
    logic res10;
  } conv_req_t;
  typedef struct packed {
    logic done;
    logic [9:0] code;
  } conv_rsp_t;
endpackage : adc_sweep_pkg

// file: dv/adc_sweep_assertions.sv
// port checks of the sweep sequencer
module adc_sweep_assertions (
  // watched ports
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire adc_sweep_pkg::conv_req_t conv_req,
  input wire adc_sweep_pkg::conv_rsp_t conv_rsp,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] last_ch;
  sequence req_gap;
    conv_req.req ##1 !conv_req.req [*2];
  endsequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) last_ch <= 4'h0;
    else if (conv_req.req) last_ch <= conv_req.channel;
  end
  apb_ok_a: assert property (pready && !pslverr) else $error("bad apb answer");
  req_pulse_a: assert property (conv_req.req |-> req_gap) else $error("req not a pulse");
  chan_range_a: assert property (conv_req.req |-> conv_req.channel < 4'hc)
    else $error("channel out of range");
  chan_step_a: assert property (conv_req.req && conv_req.channel[2:0] != 3'h0
    |-> conv_req.channel == last_ch + 4'h1) else $error("channel out of order");
  next_req_a: assert property (conv_req.req && conv_req.channel[2:0] != 3'h0
    |-> $past(conv_rsp.done) || $past(conv_rsp.done, 2)) else $error("req without done");
  irq_rise_a: assert property ($rose(irq) |-> $past(psel && penable && pwrite)
    || $past(conv_rsp.done)) else $error("irq without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("irq fell without write");
  prdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved");
endmodule : adc_sweep_assertions
bind adc_repeat_sweep_sequencer adc_sweep_assertions i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .conv_req, .conv_rsp, .irq);

// file: dv/afe_model.sv
// analog front end model answering conversion requests
module afe_model (
  // clock, reset and pacing
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  // converter handshake
  input wire adc_sweep_pkg::conv_req_t conv_req,
  output adc_sweep_pkg::conv_rsp_t conv_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic [3:0] ch;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      conv_rsp <= '0;
    end else begin
      conv_rsp.done <= cnt == 1;
      // code only valid with done, toggles otherwise
      conv_rsp.code <= cnt == 1 ? {ch, 6'h15} : ~conv_rsp.code;
      if (conv_req.req) begin
        cnt <= slow ? 10 : 6;
        ch <= conv_req.channel;
      end else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule : afe_model

// file: dv/tb_top.sv
// self-checking bench of the repeat sweep sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic pready, pslverr, irq;
  logic [2:0] trig = 3'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0] ins [7] = '{6'h00, 6'h10, 6'h01, 6'h11, 6'h02, 6'h03, 6'h12};
  logic [3:0] chq [$];
  int failures = 0, checked = 0;
  adc_sweep_pkg::conv_req_t conv_req;
  adc_sweep_pkg::conv_rsp_t conv_rsp;
  always #25 pclk = ~pclk;
  always @(negedge pclk) if (conv_req.req) chq.push_back(conv_req.channel);
  adc_repeat_sweep_sequencer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .timer_unit_one_trigger(trig[0]),
    .timer_unit_two_trigger(trig[1]), .ext_trigger(trig[2]), .conv_req, .conv_rsp, .irq);
  afe_model i_afe (.pclk, .presetn, .slow, .conv_req, .conv_rsp);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input int w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w[0];
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_reqs(input int n);
    repeat (500) if (chq.size() < n) @(posedge pclk);
    if (chq.size() < n) begin
      failures++;
      report_and_stop();
    end
  endtask : wait_reqs
  task automatic sweep(input int i);
    logic [3:0] f;
    int n;
    f = {ins[i][4], 3'h0};
    // upper group with a six or eight pin count sweeps four pins
    n = (ins[i][4] && ins[i][1]) ? 4 : 2 * (ins[i][1:0] + 1);
    slow <= i[0];
    chq.delete();
    apb(1, 12'h008, {26'h0, ins[i]});
    apb(1, 12'h004, {31'h0, i[1]});
    apb(1, 12'h014, 32'h1);
    apb(1, 12'h000, {29'h0, i[1:0], 1'b1});
    if (i[1:0] != 2'h0) begin
      repeat (8) @(posedge pclk);
      check(chq.size(), 0);
      trig[i[1:0] - 1] <= 1'b1;
      repeat (4) @(posedge pclk);
      trig <= 3'h0;
    end
    wait_reqs(n + 1);
    repeat (3) @(posedge pclk);
    check(irq, 1);
    apb(0, 12'h00c, 0);
    check(rd[0], 1);
    for (int k = 0; k < n; k++) begin
      apb(0, 12'h020 + 12'(4 * k), 0);
      check(rd, i[1] ? {22'h0, f + 4'(k), 6'h15} : {24'h0, f + 4'(k), 4'h5});
    end
    apb(1, 12'h014, 0);
    repeat (2) @(posedge pclk);
    check(irq, 0);
    wait_reqs((chq.size() / n + 1) * n + 1);
    // stop early in a sweep, no completion may follow
    apb(1, 12'h010, 1);
    apb(1, 12'h000, 0);
    for (int k = 0; k < 2 * n; k++) check(chq[k], f + 4'(k % n));
    repeat (40) @(posedge pclk);
    apb(0, 12'h010, 0);
    check(rd, 0);
  endtask : sweep
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    check(rd, 32'h0);
    apb(1, 12'h0f0, 32'hffff_ffff);
    apb(0, 12'h0f0, 0);
    check(rd, 32'h0);
    for (int i = 0; i < 7; i++) sweep(i);
    report_and_stop();
  end
endmodule : tb_top
